// [common/bram_pkg.sv]
package bram_pkg;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 36;
  localparam int ENTRY_BITS = 9;
  localparam int ENTRIES = 1024;
  localparam int ENTRY_AW = 10;
  localparam int LANES = 4;
  localparam int NARROW_MAX = 4;
  localparam int PORTS = 2;

  typedef enum logic [2:0] {
    MODE_SP = 3'b001,
    MODE_TDP = 3'b010,
    MODE_PDP = 3'b100
  } mem_mode_e;

  localparam logic [2:0] W1 = 3'h0;
  localparam logic [2:0] W2 = 3'h1;
  localparam logic [2:0] W4 = 3'h2;
  localparam logic [2:0] W9 = 3'h3;
  localparam logic [2:0] W18 = 3'h4;
  localparam logic [2:0] W36 = 3'h5;

  typedef struct packed {
    logic init_mode;
    logic rom_lock;
    logic [1:0] thru;
    logic [1:0] oreg;
    logic [1:0][2:0] width;
    mem_mode_e mode;
  } mem_cfg_s;

  localparam int CFG_W = 15;
  localparam logic [14:0] CFG_RST = 15'h40D9;
  localparam int CFG_MODE_POS = 0;
  localparam int CFG_INIT_POS = 14;

  localparam int APB_AW = 12;
  localparam logic [11:0] CFG_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] INIT_ADDR_OFS = 12'h008;
  localparam logic [11:0] INIT_DATA_OFS = 12'h00C;
  localparam int STAT_ERR_POS = 0;
  localparam int STAT_INIT_POS = 2;
  localparam int STAT_IADDR_POS = 3;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_s;

  typedef struct packed {
    logic ce;
    logic cs;
    logic we;
    logic [12:0] addr;
    logic [35:0] wdata;
  } port_req_s;

  typedef struct packed {
    logic rvalid;
    logic [35:0] rdata;
  } port_rsp_s;
endpackage : bram_pkg

// [hw/block_ram_regs.sv]
`timescale 1ns/100ps
module block_ram_regs (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire bram_pkg::apb_req_s apb_req,
  output bram_pkg::apb_rsp_s apb_rsp,
  input wire logic [1:0] cfg_err,
  output bram_pkg::mem_cfg_s cfg,
  output logic init_we,
  output logic [9:0] init_addr,
  output logic [8:0] init_data
);
  import bram_pkg::*;

  typedef struct packed {
    mem_cfg_s cfg;
    logic [9:0] iaddr;
    apb_rsp_s rsp;
  } regs_s;

  regs_s st_ff;
  regs_s nxt_st;
  logic setup;
  logic access;
  logic mode_ok;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.rsp.pready = 1'b0;
    nxt_st.rsp.pslverr = 1'b0;
    setup = apb_req.psel && !apb_req.penable;
    access = apb_req.psel && apb_req.penable && st_ff.rsp.pready;
    mode_ok = (apb_req.pwdata[2:0] == MODE_SP) || (apb_req.pwdata[2:0] == MODE_TDP) ||
      (apb_req.pwdata[2:0] == MODE_PDP);
    init_we = 1'b0;
    init_addr = st_ff.iaddr;
    init_data = apb_req.pwdata[8:0];
    // zero wait states: pready is raised during setup so access ends at once
    if (setup)
    begin
      nxt_st.rsp.pready = 1'b1;
      nxt_st.rsp.prdata = 32'h0000_0000;
      unique case (apb_req.paddr)
        CFG_OFS:
        begin
          nxt_st.rsp.prdata[CFG_W-1:0] = st_ff.cfg;
          nxt_st.rsp.pslverr = apb_req.pwrite && !mode_ok;
        end
        STATUS_OFS:
        begin
          nxt_st.rsp.prdata[STAT_ERR_POS +: 2] = cfg_err;
          nxt_st.rsp.prdata[STAT_INIT_POS] = st_ff.cfg.init_mode;
          nxt_st.rsp.prdata[STAT_IADDR_POS +: 10] = st_ff.iaddr;
        end
        INIT_ADDR_OFS: nxt_st.rsp.prdata[9:0] = st_ff.iaddr;
        INIT_DATA_OFS: nxt_st.rsp.prdata = 32'h0000_0000;
        default: nxt_st.rsp.pslverr = 1'b1;
      endcase
    end
    if (access && apb_req.pwrite && !st_ff.rsp.pslverr)
    begin
      unique case (apb_req.paddr)
        CFG_OFS: nxt_st.cfg = mem_cfg_s'(apb_req.pwdata[CFG_W-1:0]);
        INIT_ADDR_OFS: nxt_st.iaddr = apb_req.pwdata[9:0];
        // preload only while the block is still in its load phase
        INIT_DATA_OFS:
        begin
          if (st_ff.cfg.init_mode)
          begin
            init_we = 1'b1;
            nxt_st.iaddr = st_ff.iaddr + 10'h001;
          end
        end
        default: nxt_st.iaddr = st_ff.iaddr;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff.cfg <= mem_cfg_s'(CFG_RST);
      st_ff.iaddr <= 10'h000;
      st_ff.rsp <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign apb_rsp = st_ff.rsp;
  assign cfg = st_ff.cfg;
endmodule : block_ram_regs

// [hw/embedded_block_ram.sv]
`timescale 1ns/100ps
// Summary of operation
// - one 9-Kbit array, registered on its input and optionally its output side
// - modes: single port, true dual port, pseudo dual port (A writes, B reads)
// - shapes x1..x18 in every mode, x36 only outside true dual port
// - each port picks its own width and depth over the shared array
// - bits run lsb to msb of word 0, then word 1, for x9 and wider ports; x1..x4 ports skip bit 8 of each word
// - contents may be preloaded before user operation starts
// - preloaded contents with writes disabled behave as a ROM
// - address and write data are captured at the clock edge before access
// - read data straight from array or through one extra output register
// - inputs sampled on the rising edge, read data valid after that edge
// - write may show the old word (read-before-write) or the new word (write-through)
module embedded_block_ram #(
  parameter logic [8:0] INIT_ENTRY = 9'h000
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire bram_pkg::apb_req_s apb_req,
  output bram_pkg::apb_rsp_s apb_rsp,
  input wire bram_pkg::port_req_s [1:0] port_req,
  output bram_pkg::port_rsp_s [1:0] port_rsp
);
  import bram_pkg::*;

  typedef struct packed {
    logic wide;
    logic [2:0] lanes;
    logic [3:0] nmask;
    logic [9:0] entry;
    logic [2:0] off;
    logic [35:0] rd;
    logic [35:0] wword;
    logic wr_en;
    logic rd_en;
    logic err;
    logic [2:0] weff;
  } acc_s;

  typedef struct packed {
    logic [35:0] pipe;
    logic pipe_v;
    logic [35:0] dout;
    logic dout_v;
  } port_st_s;

  typedef struct packed {
    port_st_s [1:0] p;
  } state_s;

  logic [1:0] rst_sync_ff;
  logic rst_n;
  mem_cfg_s cfg;
  logic init_we;
  logic [9:0] init_addr;
  logic [8:0] init_data;
  logic [1:0] cfg_err;
  // power-up contents until software preloads its own
  logic [8:0] mem [ENTRIES] = '{default: INIT_ENTRY};
  acc_s acc [PORTS];
  state_s st_ff;
  state_s nxt_st;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      rst_sync_ff <= 2'b00;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_n = rst_sync_ff[1];

  block_ram_regs u_regs (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .apb_req(apb_req),
    .apb_rsp(apb_rsp),
    .cfg_err(cfg_err),
    .cfg(cfg),
    .init_we(init_we),
    .init_addr(init_addr),
    .init_data(init_data)
  );

  genvar gp;
  for (gp = 0; gp < PORTS; gp++)
  begin : g_port
    acc_s a;
    logic [15:0] bitaddr;
    logic [8:0] ent;
    logic [8:0] shifted;
    logic [35:0] wmask;
    logic uses;
    always_comb
    begin
      a = '0;
      uses = (gp == 0) || (cfg.mode != MODE_SP);
      // illegal shapes fall back to x18 and are flagged in status
      a.err = uses && ((cfg.width[gp] > W36) || (cfg.mode == MODE_TDP && cfg.width[gp] == W36));
      a.weff = a.err ? W18 : cfg.width[gp];
      a.wide = a.weff >= W9;
      a.lanes = 3'(3'h1 << (a.weff - W9));
      unique case (a.weff)
        W1: a.nmask = 4'h1;
        W2: a.nmask = 4'h3;
        default: a.nmask = 4'hF;
      endcase
      // narrow ports see only the low 8 bits of each entry
      bitaddr = 16'({3'h0, port_req[gp].addr} << a.weff);
      a.entry = a.wide ? 10'(port_req[gp].addr[9:0] << (a.weff - W9)) : bitaddr[12:3];
      a.off = bitaddr[2:0];
      ent = mem[a.entry];
      shifted = ent >> a.off;
      wmask = '0;
      if (a.wide)
      begin
        for (int k = 0; k < LANES; k++)
        begin
          if (k < int'(a.lanes))
          begin
            a.rd[9*k +: 9] = mem[10'(a.entry + k)];
            wmask[9*k +: 9] = 9'h1FF;
          end
        end
      end
      else
      begin
        a.rd[3:0] = shifted[3:0] & a.nmask;
        wmask[3:0] = a.nmask;
      end
      a.wword = port_req[gp].wdata & wmask;
      // write controls off in load phase and when locked as a ROM
      a.wr_en = port_req[gp].ce && port_req[gp].cs && port_req[gp].we && !cfg.init_mode &&
        !cfg.rom_lock && ((gp == 0) || (cfg.mode == MODE_TDP));
      a.rd_en = port_req[gp].ce && port_req[gp].cs && !cfg.init_mode &&
        ((gp == 0) ? (cfg.mode != MODE_PDP) : (cfg.mode != MODE_SP));
    end
    assign acc[gp] = a;
    assign cfg_err[gp] = a.err;
  end

  // port B first so port A wins a same-cycle collision on one bit
  always_ff @(posedge sys_clk)
  begin
    for (int p = PORTS - 1; p >= 0; p--)
    begin
      if (acc[p].wr_en)
      begin
        if (acc[p].wide)
        begin
          for (int k = 0; k < LANES; k++)
          begin
            if (k < int'(acc[p].lanes))
              mem[10'(acc[p].entry + k)] <= port_req[p].wdata[9*k +: 9];
          end
        end
        else
        begin
          for (int i = 0; i < NARROW_MAX; i++)
          begin
            if (acc[p].nmask[i])
              mem[acc[p].entry][3'(acc[p].off + i)] <= port_req[p].wdata[i];
          end
        end
      end
    end
    if (init_we)
      mem[init_addr] <= init_data;
  end

  always_comb
  begin
    logic [35:0] word;
    word = '0;
    nxt_st = st_ff;
    for (int p = 0; p < PORTS; p++)
    begin
      word = (acc[p].wr_en && cfg.thru[p]) ? acc[p].wword : acc[p].rd;
      if (port_req[p].ce)
      begin
        nxt_st.p[p].pipe_v = acc[p].rd_en;
        if (acc[p].rd_en)
          nxt_st.p[p].pipe = word;
        if (cfg.oreg[p])
        begin
          nxt_st.p[p].dout_v = st_ff.p[p].pipe_v;
          if (st_ff.p[p].pipe_v)
            nxt_st.p[p].dout = st_ff.p[p].pipe;
        end
        else
        begin
          nxt_st.p[p].dout_v = acc[p].rd_en;
          if (acc[p].rd_en)
            nxt_st.p[p].dout = word;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  for (gp = 0; gp < PORTS; gp++)
  begin : g_out
    assign port_rsp[gp].rvalid = st_ff.p[gp].dout_v;
    assign port_rsp[gp].rdata = st_ff.p[gp].dout;
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  rom_no_write_a: assert property (cfg.rom_lock |-> !acc[0].wr_en && !acc[1].wr_en)
    else $error("write enabled while locked as rom");
  load_blocks_user_a: assert property (cfg.init_mode |-> !acc[0].rd_en && !acc[1].wr_en && !acc[0].wr_en)
    else $error("user access during preload");
  tdp_width_cap_a: assert property (cfg.mode == MODE_TDP |-> acc[0].weff <= W18 && acc[1].weff <= W18)
    else $error("x36 used in true dual port");
  port_roles_a: assert property (cfg.mode != MODE_TDP |-> !acc[1].wr_en)
    else $error("port b wrote outside true dual port");
  pdp_a_silent_a: assert property (cfg.mode == MODE_PDP && port_req[0].ce |=> !port_rsp[0].rvalid)
    else $error("write-only port returned read data");
  read_latency_a: assert property (acc[0].rd_en && !acc[0].wr_en && !cfg.oreg[0] |=>
    port_rsp[0].rvalid && port_rsp[0].rdata == $past(acc[0].rd))
    else $error("direct read data wrong after one edge");
  oreg_latency_a: assert property (acc[0].rd_en && !acc[0].wr_en && cfg.oreg[0] ##1 port_req[0].ce && cfg.oreg[0]
    |=> port_rsp[0].rdata == $past(acc[0].rd, 2))
    else $error("registered read data not two edges late");
  old_word_out_a: assert property (acc[0].wr_en && acc[0].rd_en && !cfg.thru[0] && !cfg.oreg[0] |=>
    port_rsp[0].rdata == $past(acc[0].rd))
    else $error("read-before-write did not return old word");
  new_word_out_a: assert property (acc[0].wr_en && acc[0].rd_en && cfg.thru[0] && !cfg.oreg[0] |=>
    port_rsp[0].rdata == $past(acc[0].wword))
    else $error("write-through did not return new word");
  narrow_upper_zero_a: assert property (acc[1].rd_en && !acc[1].wide && !cfg.oreg[1] |=>
    port_rsp[1].rdata[35:4] == 32'h0000_0000)
    else $error("narrow read shows bits above its width");
  write_then_read_a: assert property (acc[0].wr_en && acc[0].wide && !acc[1].wr_en && !init_we ##1
    acc[0].rd_en && !acc[0].wr_en && !acc[1].wr_en && !cfg.oreg[0] &&
    acc[0].entry == $past(acc[0].entry) && acc[0].lanes == $past(acc[0].lanes)
    |=> port_rsp[0].rdata == $past(acc[0].wword, 2))
    else $error("word read back differs from word written");
endmodule : embedded_block_ram

// [verification/fabric_user_logic.sv]
`timescale 1ns/100ps
module fabric_user_logic
  import bram_pkg::*;
(
  input wire logic sys_clk,
  input wire bram_pkg::port_req_s [1:0] cmd,
  output bram_pkg::port_req_s [1:0] port_req
);
  initial port_req = '0;
  always @(posedge sys_clk)
  begin
    for (int p = 0; p < 2; p++)
    begin
      port_req[p] <= cmd[p];
      if (!cmd[p].cs)
      begin
        // idle lines toggle, so a stale address is never mistaken for a request
        port_req[p].addr <= ~port_req[p].addr;
        port_req[p].wdata <= ~port_req[p].wdata;
        port_req[p].we <= 1'b0;
      end
    end
  end
endmodule : fabric_user_logic

// [verification/test_embedded_block_ram.sv]
`timescale 1ns/100ps
module test_embedded_block_ram;
  import bram_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  apb_req_s apb_req = '0;
  apb_rsp_s apb_rsp;
  port_req_s [1:0] cmd = '0;
  port_req_s [1:0] port_req;
  port_rsp_s [1:0] port_rsp;
  mem_cfg_s cfg = CFG_RST;
  logic [8:0] mdl [ENTRIES];
  logic [31:0] rd;
  logic e;
  logic [35:0] w;
  logic [14:0] c;
  int bad_count = 0;
  int check_count = 0;
  int seed = 32'h7BE8;
  int p;
  int a;
  embedded_block_ram #(.INIT_ENTRY(9'h1A5)) dut (.sys_clk(sys_clk), .nrst(nrst), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .port_req(port_req), .port_rsp(port_rsp));
  fabric_user_logic fab (.sys_clk(sys_clk), .cmd(cmd), .port_req(port_req));
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic end_sim();
    if (bad_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  task automatic chk(string what, logic [35:0] seen, logic [35:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic hang();
    chk("timeout", 36'h1, 36'h0);
    end_sim();
  endtask : hang
  task automatic apb(logic wr, logic [11:0] ad, logic [31:0] d);
    int n = 0;
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: ad, pwdata: d};
    @(posedge sys_clk);
    apb_req.penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
      if (n > 8)
        hang();
    end
    while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_req <= '0;
    // one idle edge so a following call never drives the bus twice in one step
    @(posedge sys_clk);
  endtask : apb
  task automatic setcfg(logic [14:0] v);
    cfg = v;
    apb(1'b1, CFG_OFS, {17'h0, v});
    chk("cfg err", e, 1'b0);
  endtask : setcfg
  function automatic int nb(logic [2:0] x);
    return x == W1 ? 1 : x == W2 ? 2 : x == W4 ? 4 : x == W9 ? 9 : x == W18 ? 18 : 36;
  endfunction : nb
  // small window keeps ports of different widths overlapping
  function automatic int lim(logic [2:0] x, logic full);
    return ((x < W9 ? 64 : 72) << (full ? 7 : 0)) / nb(x);
  endfunction : lim
  // narrow ports see 8 bits per entry, wide ports all 9
  task automatic model(logic [2:0] x, int ad, logic we, logic [35:0] d, output logic [35:0] v);
    int k = x < W9 ? 8 : 9;
    int b;
    v = '0;
    for (int i = 0; i < nb(x); i++)
    begin
      b = ad * nb(x) + i;
      v[i] = mdl[b / k][b % k];
      if (we)
        mdl[b / k][b % k] = d[i];
    end
  endtask : model
  task automatic acc(int q, logic we, int ad, logic [35:0] d, logic ans);
    logic [35:0] v;
    logic wr = we && !cfg.rom_lock && !cfg.init_mode;
    int n = 0;
    model(cfg.width[q], ad, wr, d, v);
    if (wr && cfg.thru[q])
      v = d & ((36'h1 << nb(cfg.width[q])) - 36'h1);
    cmd[q] <= '{ce: 1'b1, cs: 1'b1, we: we, addr: ad[12:0], wdata: d};
    @(posedge sys_clk);
    cmd[q].cs <= 1'b0;
    do
    begin
      @(posedge sys_clk);
      n++;
      if (n > 4)
        hang();
    end
    while (ans && port_rsp[q].rvalid !== 1'b1);
    if (ans)
    begin
      chk("latency", 36'(n), 36'(2 + cfg.oreg[q]));
      chk("rdata", port_rsp[q].rdata, v);
    end
  endtask : acc
  initial
  begin
    foreach (mdl[i])
      mdl[i] = 9'h1A5;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    cmd[0].ce <= 1'b1;
    cmd[1].ce <= 1'b1;
    apb(1'b0, CFG_OFS, 32'h0);
    chk("cfg reset", rd, {17'h0, CFG_RST});
    apb(1'b1, INIT_ADDR_OFS, 32'h3FE);
    for (int i = 0; i < 4; i++)
    begin
      w[31:0] = $random(seed);
      apb(1'b1, INIT_DATA_OFS, w[31:0]);
      mdl[(i + 1022) % ENTRIES] = w[8:0];
    end
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("status", rd, 36'h14);
    acc(0, 1'b1, 5, 36'h0, 1'b0);
    setcfg(15'h20D9);
    acc(0, 1'b0, 5, 36'h0, 1'b1);
    acc(0, 1'b1, 1023, 36'h0, 1'b1);
    acc(0, 1'b0, 1023, 36'h0, 1'b1);
    apb(1'b1, CFG_OFS, 32'h7);
    chk("bad mode", e, 1'b1);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", {rd, e}, 36'h1);
    setcfg(15'h002A);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("x36 in dual", rd[1:0], 2'b01);
    for (int k = 0; k < 24; k++)
    begin
      c = 15'($random(seed)) & 15'h1E00;
      c[2:0] = 3'b001 << (k % 3);
      c[5:3] = 3'($unsigned($random(seed)) % (c[1] ? 5 : 6));
      c[8:6] = 3'($unsigned($random(seed)) % (c[1] ? 5 : 6));
      setcfg(c);
      for (int j = 0; j < 16; j++)
      begin
        p = c[0] ? 0 : c[2] ? j % 2 : $unsigned($random(seed)) % 2;
        // addresses stay inside one block; wider memories decode outside it
        a = $unsigned($random(seed)) % lim(cfg.width[p], 1'b0);
        if (j == 15)
          a = lim(cfg.width[p], 1'b1) - 1;
        w[31:0] = $random(seed);
        w[35:32] = 4'($random(seed));
        acc(p, c[2] ? p == 0 : w[0], a, w, !(c[2] && p == 0));
      end
    end
    // write then read one x18 word on back-to-back edges
    setcfg(15'h00E1);
    w[31:0] = $random(seed);
    w[35:32] = 4'($random(seed));
    cmd[0] <= '{ce: 1'b1, cs: 1'b1, we: 1'b1, addr: 13'h0003, wdata: w};
    @(posedge sys_clk);
    cmd[0].we <= 1'b0;
    @(posedge sys_clk);
    cmd[0].cs <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk("b2b rvalid", port_rsp[0].rvalid, 1'b1);
    chk("b2b rdata", port_rsp[0].rdata, w & 36'h0_0003_FFFF);
    end_sim();
  end
endmodule : test_embedded_block_ram
